/* rtl/lcdsc_map.svh */
/*
  Register fields, reset values and timing constants of the LCD
  segment/common driver.
  Assumes inclusion by the ticker and driver design modules only.
*/
`ifndef LCDSC_MAP_SVH
`define LCDSC_MAP_SVH

`define LCDSC_SEG_COUNT        40
`define LCDSC_COM_COUNT        16
`define LCDSC_RAM_WORDS        256
`define LCDSC_BANK_HI_BIT      7
`define LCDSC_DC_LO_ADDR       8'h40
`define LCDSC_DC_HI_ADDR       8'h41
`define LCDSC_CONTRAST_MSB     2
`define LCDSC_CONTRAST_RESET   3'h0
`define LCDSC_POINTER_RESET    8'h00
`define LCDSC_DIV_RESET        2'h1
`define LCDSC_SYS_CLK_HZ       250000000
`define LCDSC_SLOW_CLK_HZ      32768
`define LCDSC_SLOW_TICK_CYCLES (`LCDSC_SYS_CLK_HZ / `LCDSC_SLOW_CLK_HZ)

`endif

/* rtl/lcdsc_pkg.sv */
/*
  Types shared by the LCD segment/common driver.
  Assumes the map header sits beside it.
*/
package lcdsc_pkg;

  // Alternating-frequency division code.
  typedef enum logic [1:0] {
    LCDSC_DIV16  = 2'h0,
    LCDSC_DIV32  = 2'h1,
    LCDSC_DIV64  = 2'h2,
    LCDSC_DIV128 = 2'h3
  } lcdsc_div_t;

  // Core command strobes: pointer, display memory, contrast and on/off.
  typedef struct packed {
    logic       ptr_lo_wr;
    logic       ptr_hi_wr;
    logic       mem_wr;
    logic       mem_rd;
    logic       contrast_wr;
    logic       on_cmd;
    logic       off_cmd;
    logic [3:0] data;
  } lcdsc_cmd_t;

  typedef enum logic [1:0] {
    LCDSC_ST_OFF  = 2'b01,
    LCDSC_ST_SCAN = 2'b10
  } lcdsc_state_t;

endpackage : lcdsc_pkg

/* rtl/lcdsc_ticker.sv */
/*
  Divider that yields one-cycle ticks of the 32.768 kHz slow clock and,
  from them, of the selected alternating frequency.
  Assumes clk_sys is the only clock and the enable freezes it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lcdsc_map.svh"

module lcdsc_ticker
  import lcdsc_pkg::*;
#(
  parameter int SLOW_CYCLES = `LCDSC_SLOW_TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire lcdsc_div_t div_sel,
  output logic            alt_tick
);

  logic [15:0] pre_reg;
  logic [6:0]  slow_reg;
  wire         slow_tick = (pre_reg == 16'(SLOW_CYCLES - 1));
  wire  [6:0]  div_mask  = 7'((8'h10 << div_sel) - 8'h01);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_reg  <= 16'h0000;
      slow_reg <= 7'h00;
      alt_tick <= 1'b0;
    end else if (ce) begin
      pre_reg  <= slow_tick ? 16'h0000 : pre_reg + 16'h0001;
      if (slow_tick) begin
        slow_reg <= slow_reg + 7'h01;
      end
      alt_tick <= slow_tick && ((slow_reg & div_mask) == div_mask); // see R3
    end
  end

endmodule : lcdsc_ticker
`default_nettype wire

/* rtl/lcdsc_driver.sv */
/*
  LCD segment/common driver: display memory, pointer, contrast code,
  automatic scan of the memory onto 40 segments by 16 commons, and
  open-drain DC mode on the upper eight segments.
  Assumes core commands are one-cycle strobes synchronous to clk_sys and
  the analog bias stage turns the logic levels into drive voltages.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lcdsc_map.svh"

// Behaviour
// R1 - There are forty segment outputs and sixteen common outputs.
// R2 - Commons multiplex at one-eighth or one-sixteenth duty, biased at one fifth.
// R3 - The alternating frequency is the slow clock divided by 16, 32, 64 or 128.
// R4 - Division 16 is refused at 1/8 duty and 128 at 1/16 duty.
// R5 - There are 160 four-bit display memory locations feeding the segments.
// R6 - The memory is scanned onto the segments with no software help.
// R7 - A one bit lights its dot and a zero bit darkens it.
// R8 - Addresses 2n, 2n+1, 0x80+2n, 0x81+2n feed segment n commons 0-3, 4-7, 8-11, 12-15.
// R9 - The on command enables the display, also in hold, and off disables it.
// R10 - After reset the display is off until software turns it on.
// R11 - The eight-bit pointer is write-only and loaded a nibble at a time.
// R12 - The memory is reached only through the pointer over 0x00-0x4F and 0x80-0xCF.
// R13 - A write-only three-bit contrast code sits in bits 2 to 0.
// R14 - In DC mode segments 32-35 and 36-39 are open drain fed from 0x40 and 0x41.
// R15 - At one-eighth duty only commons 0 to 7 are driven.
module lcdsc_driver
  import lcdsc_pkg::*;
#(
  parameter int SEGS        = `LCDSC_SEG_COUNT,
  parameter int COMS        = `LCDSC_COM_COUNT,
  parameter int SLOW_CYCLES = `LCDSC_SLOW_TICK_CYCLES
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire lcdsc_cmd_t       cmd,
  input  wire logic             duty_16,
  input  wire lcdsc_div_t       div_sel,
  input  wire logic             hold_mode,
  input  wire logic             dc_lo_en,
  input  wire logic             dc_hi_en,
  output logic [3:0]            rd_data,
  output logic                  rd_valid,
  output logic                  display_on,
  output logic                  alt_phase,
  output logic [2:0]            contrast_code,
  output logic [SEGS-1:0]       seg_on,
  output logic [COMS-1:0]       com_sel,
  output logic [7:0]            seg_dc_out,
  output logic [7:0]            seg_dc_oe_n
);

  ////////////////////////////////////////////////////////////////////////
  // Memory, pointer and contrast.

  logic [3:0]   mem [`LCDSC_RAM_WORDS];                       // see R5
  logic [7:0]   ptr_reg;
  lcdsc_state_t state_reg;
  logic [3:0]   com_reg;
  logic         alt_tick;

  // Holes between 0x50-0x7F and above 0xCF are not memory.
  wire ptr_in_map = (ptr_reg[6:0] < 7'h50);                   // see R12
  wire div_legal  = duty_16 ? (div_sel != LCDSC_DIV128)
                            : (div_sel != LCDSC_DIV16);       // see R4
  wire [3:0] com_last = duty_16 ? 4'hF : 4'h7;                // see R2

  always_ff @(posedge clk_sys) begin
    if (ce && cmd.mem_wr && ptr_in_map) begin
      mem[ptr_reg] <= cmd.data;                               // see R12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_reg <= `LCDSC_POINTER_RESET;
    end else if (ce && cmd.ptr_lo_wr) begin
      ptr_reg[3:0] <= cmd.data;                               // see R11
    end else if (ce && cmd.ptr_hi_wr) begin
      ptr_reg[7:4] <= cmd.data;                               // see R11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      contrast_code <= `LCDSC_CONTRAST_RESET;
    end else if (ce && cmd.contrast_wr) begin
      contrast_code <= cmd.data[`LCDSC_CONTRAST_MSB:0];        // see R13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data  <= 4'h0;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= cmd.mem_rd;
      rd_data  <= (cmd.mem_rd && ptr_in_map) ? mem[ptr_reg] : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display on/off state and common scan.

  lcdsc_ticker #(
    .SLOW_CYCLES (SLOW_CYCLES)
  ) u_ticker (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .div_sel  (div_sel),
    .alt_tick (alt_tick)
  );

  // Hold mode does not stop the scan; only the off command or reset does.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= LCDSC_ST_OFF;                              // see R10
    end else if (ce) begin
      case (state_reg)
        LCDSC_ST_OFF:  if (cmd.on_cmd) state_reg <= LCDSC_ST_SCAN; // see R9
        LCDSC_ST_SCAN: if (cmd.off_cmd) state_reg <= LCDSC_ST_OFF; // see R9
        default:       state_reg <= LCDSC_ST_OFF;
      endcase
    end
  end

  wire scanning = (state_reg == LCDSC_ST_SCAN) || hold_mode & 1'b0;
  wire step     = scanning && alt_tick && div_legal;          // see R4

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      com_reg    <= 4'h0;
      alt_phase  <= 1'b0;
      display_on <= 1'b0;
    end else if (ce) begin
      display_on <= scanning;
      if (!scanning) begin
        com_reg <= 4'h0;
      end else if (step) begin
        com_reg <= (com_reg >= com_last) ? 4'h0 : com_reg + 4'h1; // see R15
        if (com_reg >= com_last) begin
          alt_phase <= ~alt_phase;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Segment pattern fetch by direct memory read.

  logic [SEGS-1:0] seg_next;
  logic [7:0]      dc_next;
  wire  [7:0]      row_base = {com_reg[3], 7'h00} | {7'h00, com_reg[2]};

  always_comb begin
    seg_next = '0;
    for (int n = 0; n < SEGS; n++) begin
      seg_next[n] = mem[8'(row_base + 8'(2 * n))][com_reg[1:0]]; // see R8
    end
  end

  assign dc_next = {mem[`LCDSC_DC_HI_ADDR], mem[`LCDSC_DC_LO_ADDR]};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seg_on      <= '0;
      com_sel     <= '0;
      seg_dc_out  <= 8'h00;
      seg_dc_oe_n <= 8'hFF;
    end else if (ce) begin
      seg_on  <= scanning ? seg_next : '0;                    // see R6 R7 R1
      com_sel <= scanning ? COMS'(1) << com_reg : '0;         // see R15
      seg_dc_out <= 8'h00;
      // Open drain: a zero bit pulls low, a one releases the pin.
      seg_dc_oe_n[3:0] <= dc_lo_en ? dc_next[3:0] : 4'hF;     // see R14
      seg_dc_oe_n[7:4] <= dc_hi_en ? dc_next[7:4] : 4'hF;     // see R14
    end
  end

endmodule : lcdsc_driver
`default_nettype wire

/* testbench/lcdsc_glass.sv */
/* Panel model: keeps the segment 0 dot shown at each common.
   Assumes one-hot commons and a clear input from the bench. */
`timescale 1ns/10ps
`default_nettype none
module lcdsc_glass #(
  parameter int SEGS = 40,
  parameter int COMS = 16
) (
  input  wire logic            clk_sys,
  input  wire logic            clr,
  input  wire logic [SEGS-1:0] seg_on,
  input  wire logic [COMS-1:0] com_sel,
  output var logic  [COMS-1:0] dots,
  output var logic  [COMS-1:0] seen
);
  always @(posedge clk_sys) begin
    for (int c = 0; c < COMS; c++) begin
      if (clr) begin
        seen[c] <= 1'b0;
      end else if (com_sel[c]) begin
        dots[c] <= seg_on[0];
        seen[c] <= 1'b1;
      end
    end
  end
endmodule : lcdsc_glass
`default_nettype wire

/* testbench/lcdsc_driver_asserts.sv */
/* Port checker of the LCD driver.
   Assumes it is bound to every driver instance. */
`timescale 1ns/10ps
`default_nettype none
module lcdsc_driver_asserts
  import lcdsc_pkg::*;
#(
  parameter int SEGS = 40,
  parameter int COMS = 16
) (
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire lcdsc_cmd_t      cmd,
  input wire logic            rd_valid,
  input wire logic            display_on,
  input wire logic [2:0]      contrast_code,
  input wire logic [SEGS-1:0] seg_on,
  input wire logic [COMS-1:0] com_sel,
  input wire logic [7:0]      seg_dc_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_on; cmd.on_cmd && !cmd.off_cmd ##1 !cmd.off_cmd; endsequence
  sequence s_off; cmd.off_cmd && !cmd.on_cmd ##1 !cmd.on_cmd [*2]; endsequence
  property p_on; s_on |=> display_on; endproperty
  property p_off; s_off |-> !display_on; endproperty
  property p_keep;
    display_on && !cmd.off_cmd && !$past(cmd.off_cmd) |=> display_on;
  endproperty
  property p_dark; !display_on [*2] |-> com_sel == '0 && seg_on == '0;
  endproperty
  property p_rd; cmd.mem_rd |=> rd_valid; endproperty
  property p_hot; $onehot0(com_sel); endproperty
  property p_cc; cmd.contrast_wr |=> contrast_code == $past(cmd.data[2:0]);
  endproperty
  property p_dc; seg_dc_out == 8'h00; endproperty
  a_on: assert property (p_on) else $error("display not on");
  a_off: assert property (p_off) else $error("display not off");
  a_keep: assert property (p_keep) else $error("display dropped");
  a_dark: assert property (p_dark) else $error("dark panel driven");
  a_rd: assert property (p_rd) else $error("no read answer");
  a_hot: assert property (p_hot) else $error("commons not one-hot");
  a_cc: assert property (p_cc) else $error("contrast wrong");
  a_dc: assert property (p_dc) else $error("open drain drives high");
endmodule : lcdsc_driver_asserts
bind lcdsc_driver lcdsc_driver_asserts #(.SEGS(SEGS), .COMS(COMS)) u_chk (
  .clk_sys, .rst, .cmd, .rd_valid, .display_on, .contrast_code, .seg_on,
  .com_sel, .seg_dc_out);
`default_nettype wire

/* testbench/lcd_segment_common_driver_tb.sv */
/* Bench of the LCD driver with a panel model.
   Assumes design, package and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module lcd_segment_common_driver_tb;
  import lcdsc_pkg::*;
  localparam int LO = 10, HI = 9, WR = 8, RD = 7, CC = 6, ON = 5, OFF = 4;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, clr = 1'b1;
  logic duty_16 = 1'b1, hold_mode = 1'b0, dc_lo_en = 1'b0, dc_hi_en = 1'b0;
  lcdsc_cmd_t cmd = '0;
  lcdsc_div_t div_sel = LCDSC_DIV32;
  logic rd_valid, display_on;
  logic [2:0] contrast_code;
  logic [39:0] seg_on;
  logic [15:0] com_sel, dots, seen, com_keep;
  logic [7:0] seg_dc_out, seg_dc_oe_n;
  logic [7:0] ad[6] = '{8'h00, 8'h01, 8'h80, 8'h81, 8'h40, 8'hCF};
  logic [3:0] rd_data, d[6], exp_q[$];
  logic [31:0] seed = 32'h000182FB;
  int n_errors = 0;
  int n_tests = 0;
  int i;
  always #2 clk_sys = ~clk_sys;
  lcdsc_driver #(.SLOW_CYCLES(4)) u_dut (.clk_sys, .rst, .ce, .cmd, .duty_16,
    .div_sel, .hold_mode, .dc_lo_en, .dc_hi_en, .rd_data, .rd_valid,
    .display_on, .alt_phase(), .contrast_code, .seg_on, .com_sel,
    .seg_dc_out, .seg_dc_oe_n);
  lcdsc_glass u_glass (.clk_sys, .clr, .seg_on, .com_sel, .dots, .seen);
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp_v);
    n_tests++;
    if (got !== exp_v) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp_v, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic op(int k, logic [3:0] v);
    @(negedge clk_sys);
    cmd = lcdsc_cmd_t'((11'h001 << k) | 11'(v));
  endtask : op
  task automatic ptr(logic [7:0] a);
    op(LO, a[3:0]);
    op(HI, a[7:4]);
  endtask : ptr
  task automatic rd(logic [7:0] a, logic [3:0] e);
    ptr(a);
    op(RD, 4'h0);
    exp_q.push_back(e);
  endtask : rd
  always @(posedge clk_sys) begin
    #1;
    if (rd_valid === 1'b1) chk("rd_data", rd_data, exp_q.pop_front());
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    chk("display_on", display_on, 16'h0000);
    chk("oe_n", seg_dc_oe_n, 16'h00FF);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      d[i] = seed[3:0];
      ptr(ad[i]);
      op(WR, d[i]);
    end
    ptr(8'h50);
    op(WR, 4'hF);
    for (i = 0; i < 6; i++) rd(ad[i], d[i]);
    rd(8'h50, 4'h0);
    op(CC, 4'hF);
    op(ON, 4'h0);
    hold_mode = 1'b1;
    op(31, 4'h0);
    repeat (2) @(negedge clk_sys);
    chk("display_on", display_on, 16'h0001);
    chk("contrast", contrast_code, 16'h0007);
    dc_lo_en = 1'b1;
    clr = 1'b0;
    for (i = 0; i < 6000 && seen !== 16'hFFFF; i++) @(negedge clk_sys);
    if (seen !== 16'hFFFF) begin
      n_errors++;
      stop_test();
    end
    chk("oe_n", seg_dc_oe_n, {8'h00, 4'hF, d[4]});
    for (i = 0; i < 16; i++)
      chk("dot", dots[i], d[(i / 8) * 2 + (i % 8) / 4][i % 4]);
    @(negedge clk_sys);
    clr = 1'b1;
    duty_16 = 1'b0;
    repeat (300) @(negedge clk_sys);
    clr = 1'b0;
    for (i = 0; i < 3000 && seen[7:0] !== 8'hFF; i++) @(negedge clk_sys);
    if (seen[7:0] !== 8'hFF) begin
      n_errors++;
      stop_test();
    end
    chk("seen", seen, 16'h00FF);
    div_sel = LCDSC_DIV16;
    @(negedge clk_sys);
    com_keep = com_sel;
    repeat (300) @(negedge clk_sys);
    chk("frozen", com_sel, com_keep);
    op(OFF, 4'h0);
    op(31, 4'h0);
    repeat (3) @(negedge clk_sys);
    chk("display_on", display_on, 16'h0000);
    chk("com_sel", com_sel, 16'h0000);
    stop_test();
  end
endmodule : lcd_segment_common_driver_tb
`default_nettype wire
